// [testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	import ubt_pkg::*;
	logic        CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, EXT_BAUD_CLK = 1'b0;  // clocks, strobe
	logic [15:0] ADDR = 16'h0000;                                           // register address
	logic [7:0]  WDATA = 8'h00, RDATA, RX_CHAR = 8'h00, RX_CHAR_OUT;       // data buses
	logic        RX_PRI = 1'b1, RX_ALT = 1'b1, TX_PRI, TX_ALT, RX_SERIAL;  // pins
	logic        TX_DONE_IRQ, TX_DONE_FLAG, TX_FLAG_CLR = 1'b0;            // completion
	logic        RX_PAR_BIT = 1'b0, RX_CHECK = 1'b0, RX_PAR_ERR;           // parity check
	int          err_total = 0;                                             // mismatches
	int          checks = 0;                                                // comparisons
	always #5 CLK = ~CLK;
	// external baud pin: 40 ns period, so one pin period is four system cycles
	always #20 EXT_BAUD_CLK = ~EXT_BAUD_CLK;
	ubt_top ubt_top_i (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .WDATA(WDATA),
		.RDATA(RDATA), .EXT_BAUD_CLK(EXT_BAUD_CLK), .RX_PRI(RX_PRI), .RX_ALT(RX_ALT),
		.TX_PRI(TX_PRI), .TX_ALT(TX_ALT), .TX_DONE_IRQ(TX_DONE_IRQ),
		.TX_DONE_FLAG(TX_DONE_FLAG), .TX_FLAG_CLR(TX_FLAG_CLR), .RX_CHAR(RX_CHAR),
		.RX_PAR_BIT(RX_PAR_BIT), .RX_CHECK(RX_CHECK), .RX_PAR_ERR(RX_PAR_ERR),
		.RX_CHAR_OUT(RX_CHAR_OUT), .RX_SERIAL(RX_SERIAL));
	ubt_remote ubt_remote_i (.clk(CLK), .pri(TX_PRI), .alt(TX_ALT));
	// expected parity bit; seven-bit characters lose bit 7 first
	function automatic logic exp_par(input logic [7:0] d, input logic cl, input logic [1:0] pm);
		logic [7:0] m;
		m = cl ? d : {1'b0, d[6:0]};
		case (pm)
			UBT_PAR_EVEN: return ^m;
			UBT_PAR_ODD: return ~^m;
			default: return 1'b0;
		endcase
	endfunction : exp_par
	// bit length in system cycles for the chosen source
	function automatic int bit_cycles(input logic [3:0] ps, input logic [3:0] k,
	                                  input logic osc_halve_sel, input logic ext);
		if (ext) begin
			return 8 * (k + 16);
		end
		return (osc_halve_sel ? 1 : 2) * (ps == 4'h0 ? 2048 : 1 << (ps - 4)) * (k + 16);
	endfunction : bit_cycles
	// one register write, strobe held for a single edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		#1 ADDR = a;
		WDATA = d;
		WR = 1'b1;
		@(posedge CLK);
		#1 WR = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge CLK);
		#1 ADDR = a;
		#1 d = RDATA;
	endtask : rd
	// configure, send one character, then try a refused second write
	task automatic frame(input logic [7:0] d, input logic [3:0] ps, input logic osc_halve_sel,
	                     input logic ext, input logic [1:0] pm, input logic cl,
	                     input logic sl, input logic sel);
		logic [3:0] k;
		logic [7:0] ch;
		logic pb;
		logic bad;
		int per;
		int w;
		k = 4'($urandom_range(14));
		per = bit_cycles(ps, k, osc_halve_sel, ext);
		// routing and mode rewritten only while the line is idle
		wr(PIN_SEL_ADDR, {2'b00, sel, sel, 4'h0});
		wr(OSC_MODE_ADDR, {7'h00, osc_halve_sel});
		wr(BAUD_GEN_ADDR, {ps, k});
		wr(MODE_ADDR, {2'b10, pm, cl, sl, 1'b0, ~ext});
		fork
			ubt_remote_i.get_frame(sel, per, cl ? 8 : 7, pm != 2'b00, sl ? 2 : 1, ch, pb, bad);
			begin
				wr(TX_SHIFT_ADDR, d);
				wr(TX_SHIFT_ADDR, ~d);
			end
		join
		w = 0;
		#1;
		while (TX_DONE_IRQ !== 1'b1 && w < per) begin
			@(posedge CLK);
			#1 w++;
		end
		`CHK("irq", 1'b1, TX_DONE_IRQ)
		@(posedge CLK);
		#1 `CHK("flag", 1'b1, TX_DONE_FLAG)
		// the write made while busy must not start a second frame
		repeat (per) begin
			@(posedge CLK);
			#1 bad |= (sel ? TX_ALT : TX_PRI) !== 1'b1;
		end
		`CHK("frame", 1'b0, bad)
		`CHK("char", d & (cl ? 8'hff : 8'h7f), ch)
		`CHK("parity", exp_par(d, cl, pm), pb)
		TX_FLAG_CLR = 1'b1;
		@(posedge CLK);
		#1 TX_FLAG_CLR = 1'b0;
		`CHK("flag clear", 1'b0, TX_DONE_FLAG)
	endtask : frame
	task automatic summarize();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// main sequence: registers, frames, receive parity check, input routing
	initial begin
		logic [7:0] v;
		logic [7:0] c;
		logic p;
		void'($urandom(32'hb6fa));
		repeat (2) @(posedge CLK);
		#1 RST_N = 1'b1;
		rd(PIN_SEL_ADDR, v);
		`CHK("pin sel reset", PIN_SEL_RST, v)
		rd(BAUD_GEN_ADDR, v);
		`CHK("baud reset", BAUD_GEN_RST, v)
		wr(PIN_SEL_ADDR, 8'hff);
		rd(PIN_SEL_ADDR, v);
		`CHK("pin sel rw", 8'h30, v)
		wr(BAUD_GEN_ADDR, 8'ha5);
		rd(BAUD_GEN_ADDR, v);
		`CHK("baud rw", 8'ha5, v)
		rd(16'hff7f, v);
		`CHK("unmapped", 8'h00, v)
		for (int i = 0; i < 16; i++) begin
			frame(i == 0 ? 8'hff : 8'($urandom), 4'h5 + 4'($urandom_range(1)), 1'($urandom),
			      i[1:0] == 2'b11, i[3:2], i[0], i[1], 1'($urandom));
		end
		for (int i = 0; i < 12; i++) begin
			c = 8'($urandom);
			p = 1'($urandom);
			wr(MODE_ADDR, {2'b01, i[1:0], i[2], 3'b001});
			RX_CHAR = c;
			RX_PAR_BIT = p;
			RX_CHECK = 1'b1;
			@(posedge CLK);
			#1 RX_CHECK = 1'b0;
			`CHK("par err", i[1] & (exp_par(c, i[2], i[1:0]) ^ p), RX_PAR_ERR)
			`CHK("rx char", c & (i[2] ? 8'hff : 8'h7f), RX_CHAR_OUT)
		end
		for (int s = 0; s < 4; s++) begin
			wr(PIN_SEL_ADDR, {3'b000, s[0], 4'h0});
			RX_PRI = s[1];
			RX_ALT = ~s[1];
			repeat (4) @(posedge CLK);
			#1 `CHK("rx route", s[0] ^ s[1], RX_SERIAL)
		end
		summarize();
	end
	// hang guard, well beyond the longest expected run
	initial begin
		#1_000_000;
		err_total++;
		summarize();
	end
endmodule : testbench

// [ubt_pkg.sv]
package ubt_pkg;
	// register offsets
	localparam logic [15:0] PIN_SEL_ADDR   = 16'hff75;        // pin routing register
	localparam logic [15:0] MODE_ADDR      = 16'hff70;        // serial mode register
	localparam logic [15:0] BAUD_GEN_ADDR  = 16'hff73;        // baud generator control
	localparam logic [15:0] TX_SHIFT_ADDR  = 16'hff74;        // transmit shift register
	localparam logic [15:0] OSC_MODE_ADDR  = 16'hff76;        // oscillation mode register
	// reset values
	localparam logic [7:0]  PIN_SEL_RST    = 8'h00;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [7:0]  BAUD_GEN_RST   = 8'h00;
	// field positions
	localparam int          TX_ALT_BIT     = 5;               // output pin select
	localparam int          RX_ALT_BIT     = 4;               // input pin select
	localparam int          TXE_BIT        = 7;               // transmit enable
	localparam int          RXE_BIT        = 6;               // receive enable
	localparam int          CL_BIT         = 3;               // character length
	localparam int          SL_BIT         = 2;               // stop length
	localparam int          SCK_BIT        = 0;               // 1: internal generator
	localparam logic [3:0]  DIV_BASE       = 4'h0;            // k offset base
	localparam logic [4:0]  DIV_ADD        = 5'h10;           // the +16 of k+16
	// parity modes
	typedef enum logic [1:0] {
		UBT_PAR_NONE = 2'b00,
		UBT_PAR_ZERO = 2'b01,
		UBT_PAR_ODD  = 2'b10,
		UBT_PAR_EVEN = 2'b11
	} ubt_par_t;
	// transmitter states
	typedef enum logic [2:0] {
		UBT_IDLE  = 3'b000,
		UBT_START = 3'b001,
		UBT_DATA  = 3'b010,
		UBT_PAR   = 3'b011,
		UBT_STOP  = 3'b100
	} ubt_st_t;
endpackage : ubt_pkg

// [ubt_remote.sv]
`timescale 1ns/1ps
// far station: samples the device output line at bit centres
module ubt_remote (
	input wire logic clk, // time base shared with the device
	input wire logic pri, // device primary output pin
	input wire logic alt  // device alternate output pin
);
	// decode one frame; per is the bit length in clk cycles
	task automatic get_frame(input logic sel, input int per, input int nb, input int np,
	                         input int ns, output logic [7:0] ch, output logic pb,
	                         output logic bad);
		int w;
		logic ln;
		ch = 8'h00;
		pb = 1'b0;
		w = 0;
		// the line idles high until the start bit
		// sampled on the falling edge, away from the edge that launches the line
		while ((sel ? alt : pri) !== 1'b0 && w < 400) begin
			@(negedge clk);
			w++;
		end
		bad = (w >= 400);
		// centre of start bit must still be low
		repeat (per / 2) @(negedge clk);
		bad |= (sel ? alt : pri) !== 1'b0;
		for (int i = 0; i < nb + np + ns; i++) begin
			repeat (per) @(negedge clk);
			ln = sel ? alt : pri;
			// unselected pin must stay parked high
			bad |= (sel ? pri : alt) !== 1'b1;
			if (i < nb) begin
				ch[i] = ln; // least significant bit arrives first
			end else if (i < nb + np) begin
				pb = ln;
			end else begin
				bad |= ln !== 1'b1; // stop bits high
			end
		end
	endtask : get_frame
endmodule : ubt_remote

// [ubt_top.sv]
`timescale 1ns/1ps
module ubt_top (
	input  wire logic        CLK,          // fx, 100 MHz
	input  wire logic        RST_N,        // synchronous reset, active low
	input  wire logic [15:0] ADDR,         // register address
	input  wire logic        WR,           // write strobe
	input  wire logic [7:0]  WDATA,        // write data
	output logic      [7:0]  RDATA,        // read data
	input  wire logic        EXT_BAUD_CLK, // external baud clock pin
	input  wire logic        RX_PRI,       // primary input pin
	input  wire logic        RX_ALT,       // alternate input pin
	output logic             TX_PRI,       // primary output pin
	output logic             TX_ALT,       // alternate output pin
	output logic             TX_DONE_IRQ,  // transmit completion pulse
	output logic             TX_DONE_FLAG, // sticky completion flag
	input  wire logic        TX_FLAG_CLR,  // software clears the flag
	input  wire logic [7:0]  RX_CHAR,      // received character from receive section
	input  wire logic        RX_PAR_BIT,   // received parity bit
	input  wire logic        RX_CHECK,     // pulse: check parity now
	output logic             RX_PAR_ERR,   // parity error pulse
	output logic      [7:0]  RX_CHAR_OUT,  // character, bit 7 masked in 7-bit mode
	output logic             RX_SERIAL     // routed, synchronised input
);
	import ubt_pkg::*;
	typedef struct packed {
		logic [7:0] pin_sel;    // routing register
		logic [7:0] mode;       // mode register
		logic [7:0] baud;       // baud generator control
		logic       halve;      // oscillation halving select
		logic [1:0] rx_pri_s;   // primary input synchroniser
		logic [1:0] rx_alt_s;   // alternate input synchroniser
		logic       rx_line;    // routed input, selected after both syncs
		logic [2:0] ext_s;      // external clock sync plus edge history
		logic       halve_ph;   // fx/2 phase
		logic [10:0] pre_cnt;   // prescaler counter
		logic [4:0] div_cnt;    // k+16 counter
		logic       ext_ph;     // 2x divider on external clock
		ubt_st_t    st;         // transmitter state
		logic [7:0] shreg;      // transmit shifter
		logic [2:0] bit_cnt;    // data bit index
		logic       stop_cnt;   // second stop bit pending
		logic       par_bit;    // computed parity
		logic       tx_line;    // serial output
		logic       irq;        // completion pulse
		logic       flag;       // sticky completion
		logic       perr;       // parity error pulse
		logic [7:0] rx_char;    // masked received character
	} ubt_state_t;
	ubt_state_t s_q, s_d;
	ubt_par_t   par_mode;
	logic [3:0] pre_code;
	logic [3:0] n_val;
	logic       fxx_tick;
	logic       pre_tick;
	logic       bit_tick;
	logic       ext_rise;
	logic       src_tick;
	logic [7:0] char_eff;
	logic       rx_ones;

	assign par_mode = ubt_par_t'(s_q.mode[5:4]);
	assign pre_code = s_q.baud[7:4];
	// prescaler code to n; prohibited codes fall back to n=11
	always_comb begin
		unique case (pre_code)
			4'h0:    n_val = 4'hb;
			4'h5:    n_val = 4'h1;
			4'h6:    n_val = 4'h2;
			4'h7:    n_val = 4'h3;
			4'h8:    n_val = 4'h4;
			4'h9:    n_val = 4'h5;
			4'ha:    n_val = 4'h6;
			4'hb:    n_val = 4'h7;
			4'hc:    n_val = 4'h8;
			4'hd:    n_val = 4'h9;
			4'he:    n_val = 4'ha;
			default: n_val = 4'hb;
		endcase
	end
	// fxx: every clock, or every second clock when halved
	assign fxx_tick = !s_q.halve || s_q.halve_ph;
	// prescaler wraps after 2^n fxx ticks
	assign pre_tick = fxx_tick && (s_q.pre_cnt == 11'((32'd1 << n_val) - 1));
	// external clock rising edge, counted once per two edges
	assign ext_rise = s_q.ext_s[1] && !s_q.ext_s[2];
	assign src_tick = s_q.mode[SCK_BIT] ? pre_tick : (ext_rise && s_q.ext_ph);
	// one bit period after k+16 source ticks
	assign bit_tick = src_tick && (s_q.div_cnt == (DIV_ADD + {1'b0, s_q.baud[3:0]} - 5'd1));
	// 7-bit mode ignores the top bit
	assign char_eff = s_q.mode[CL_BIT] ? s_q.shreg : {1'b0, s_q.shreg[6:0]};
	assign rx_ones  = ^RX_CHAR[6:0] ^ (RX_CHAR[7] & s_q.mode[CL_BIT]) ^ RX_PAR_BIT;

	// next-state logic for the whole block
	always_comb begin
		s_d = s_q;
		s_d.irq  = 1'b0;
		s_d.perr = 1'b0;
		s_d.rx_pri_s = {s_q.rx_pri_s[0], RX_PRI};
		s_d.rx_alt_s = {s_q.rx_alt_s[0], RX_ALT};
		s_d.rx_line  = s_q.pin_sel[RX_ALT_BIT] ? s_q.rx_alt_s[1] : s_q.rx_pri_s[1];
		s_d.ext_s = {s_q.ext_s[1:0], EXT_BAUD_CLK};
		s_d.halve_ph = !s_q.halve_ph;
		if (fxx_tick)
			s_d.pre_cnt = pre_tick ? 11'h000 : 11'(s_q.pre_cnt + 11'h001);
		if (ext_rise)
			s_d.ext_ph = !s_q.ext_ph;
		if (src_tick)
			s_d.div_cnt = bit_tick ? 5'h00 : 5'(s_q.div_cnt + 5'h01);
		// register writes; the transmit write is taken only while idle
		if (WR) begin
			unique case (ADDR)
				PIN_SEL_ADDR:  s_d.pin_sel = WDATA & 8'h30;
				MODE_ADDR:     s_d.mode    = WDATA;
				BAUD_GEN_ADDR: s_d.baud    = WDATA;
				OSC_MODE_ADDR: s_d.halve   = !WDATA[0];  // bit set selects fx
				default: ;
			endcase
		end
		// receive parity check; zero and none modes never flag
		if (RX_CHECK) begin
			s_d.rx_char = s_q.mode[CL_BIT] ? RX_CHAR : {1'b0, RX_CHAR[6:0]};
			if (par_mode == UBT_PAR_EVEN)
				s_d.perr = rx_ones;
			else if (par_mode == UBT_PAR_ODD)
				s_d.perr = !rx_ones;
			else
				s_d.perr = 1'b0;
		end
		// transmitter
		unique case (s_q.st)
			UBT_IDLE: begin
				if (WR && ADDR == TX_SHIFT_ADDR && s_q.mode[TXE_BIT]) begin
					s_d.shreg = WDATA;
					s_d.st    = UBT_START;
					s_d.div_cnt = 5'h00;
					s_d.pre_cnt = 11'h000;
				end
			end
			UBT_START: begin
				s_d.bit_cnt = 3'h0;
				s_d.par_bit = ^char_eff;
				if (bit_tick)
					s_d.st = UBT_DATA;
			end
			UBT_DATA: begin
				if (bit_tick) begin
					s_d.bit_cnt = 3'(s_q.bit_cnt + 3'h1);
					if (s_q.bit_cnt == (s_q.mode[CL_BIT] ? 3'h7 : 3'h6)) begin
						s_d.stop_cnt = s_q.mode[SL_BIT];
						s_d.st = (par_mode == UBT_PAR_NONE) ? UBT_STOP : UBT_PAR;
					end
				end
			end
			UBT_PAR: begin
				if (bit_tick)
					s_d.st = UBT_STOP;
			end
			UBT_STOP: begin
				if (bit_tick) begin
					if (s_q.stop_cnt)
						s_d.stop_cnt = 1'b0;
					else begin
						s_d.st   = UBT_IDLE;
						s_d.irq  = 1'b1;
					end
				end
			end
			default: s_d.st = UBT_IDLE;
		endcase
		// set wins over software clear
		if (TX_FLAG_CLR)
			s_d.flag = 1'b0;
		if (s_d.irq)
			s_d.flag = 1'b1;
		if (!s_q.mode[TXE_BIT])
			s_d.st = UBT_IDLE;
		// line follows the state being entered, so every bit lasts one full period
		unique case (s_d.st)
			UBT_START: s_d.tx_line = 1'b0;
			UBT_DATA:  s_d.tx_line = s_d.shreg[s_d.bit_cnt];   // lsb first
			UBT_PAR: begin
				unique case (par_mode)
					UBT_PAR_EVEN: s_d.tx_line = s_d.par_bit;
					UBT_PAR_ODD:  s_d.tx_line = !s_d.par_bit;
					default:      s_d.tx_line = 1'b0;
				endcase
			end
			default:   s_d.tx_line = 1'b1;                     // idle and stop
		endcase
	end

	// state register, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_q         <= '0;
			s_q.pin_sel <= PIN_SEL_RST;
			s_q.mode    <= MODE_RST;
			s_q.baud    <= BAUD_GEN_RST;
			s_q.halve   <= 1'b1;
			s_q.rx_pri_s <= 2'b11;
			s_q.rx_alt_s <= 2'b11;
			s_q.rx_line <= 1'b1;
			s_q.tx_line <= 1'b1;
			s_q.st      <= UBT_IDLE;
		end else
			s_q <= s_d;
	end

	// read mux
	always_comb begin
		unique case (ADDR)
			PIN_SEL_ADDR:  RDATA = s_q.pin_sel;
			MODE_ADDR:     RDATA = s_q.mode;
			BAUD_GEN_ADDR: RDATA = s_q.baud;
			OSC_MODE_ADDR: RDATA = {7'h00, !s_q.halve};
			default:       RDATA = 8'h00;
		endcase
	end

	// pin routing; unused output idles high
	assign TX_PRI = s_q.pin_sel[TX_ALT_BIT] ? 1'b1 : s_q.tx_line;
	assign TX_ALT = s_q.pin_sel[TX_ALT_BIT] ? s_q.tx_line : 1'b1;
	assign TX_DONE_IRQ  = s_q.irq;
	assign TX_DONE_FLAG = s_q.flag;
	assign RX_PAR_ERR   = s_q.perr;
	assign RX_CHAR_OUT  = s_q.rx_char;
	assign RX_SERIAL    = s_q.rx_line;

	// assertions
	property p_idle_high;
		@(posedge CLK) disable iff (!RST_N)
		(s_q.st == UBT_IDLE) |-> s_q.tx_line;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not high when idle");
	property p_start_low;
		@(posedge CLK) disable iff (!RST_N)
		(s_q.st == UBT_START) |-> !s_q.tx_line;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_irq_flag;
		@(posedge CLK) disable iff (!RST_N)
		s_q.irq |-> s_q.flag && $past(s_q.st) == UBT_STOP;
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq without flag or stop");
	property p_none_skip;
		@(posedge CLK) disable iff (!RST_N)
		(par_mode == UBT_PAR_NONE) |-> s_q.st != UBT_PAR;
	endproperty
	a_none_skip: assert property (p_none_skip) else $error("parity sent in none mode");
	property p_zero_noerr;
		@(posedge CLK) disable iff (!RST_N)
		(RX_CHECK && !s_q.mode[5]) |=> !s_q.perr;
	endproperty
	a_zero_noerr: assert property (p_zero_noerr) else $error("parity error in zero/none");
	property p_even_err;
		@(posedge CLK) disable iff (!RST_N)
		(RX_CHECK && par_mode == UBT_PAR_EVEN) |=> s_q.perr == $past(rx_ones);
	endproperty
	a_even_err: assert property (p_even_err) else $error("even parity check wrong");
	property p_odd_err;
		@(posedge CLK) disable iff (!RST_N)
		(RX_CHECK && par_mode == UBT_PAR_ODD) |=> s_q.perr != $past(rx_ones);
	endproperty
	a_odd_err: assert property (p_odd_err) else $error("odd parity check wrong");
	property p_seven_bit;
		@(posedge CLK) disable iff (!RST_N)
		(RX_CHECK && !s_q.mode[CL_BIT]) |=> !s_q.rx_char[7];
	endproperty
	a_seven_bit: assert property (p_seven_bit) else $error("bit 7 set in 7-bit mode");
	property p_start_go;
		@(posedge CLK) disable iff (!RST_N)
		(s_q.st == UBT_IDLE && s_q.mode[TXE_BIT] && WR && ADDR == TX_SHIFT_ADDR)
			|=> s_q.st == UBT_START;
	endproperty
	a_start_go: assert property (p_start_go) else $error("write did not start frame");
endmodule : ubt_top
